/* File: design/abr_defs.svh */
`ifndef ABR_DEFS_SVH
`define ABR_DEFS_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ABR_OFF_BRIDGE_CONTROL 8'h3c
`define ABR_OFF_ERROR_COMMAND 8'h40
`define ABR_OFF_COMMAND 8'h44
`define ABR_OFF_IO_WINDOW 8'h48
`define ABR_OFF_MEM_WINDOW 8'h4c
`define ABR_OFF_PREF_WINDOW 8'h50
`define ABR_OFF_IRQ_STATUS 8'h54
`define ABR_OFF_IRQ_MASK 8'h58
// ---------------------------------------------------------------
// Field positions and write masks
// ---------------------------------------------------------------
`define ABR_BC_PARITY_BIT 0
`define ABR_BC_ISA_BIT 2
`define ABR_BC_VIDEO_BIT 3
`define ABR_BC_WMASK 8'h0d
`define ABR_EC_TA_BIT 0
`define ABR_EC_WMASK 8'h01
`define ABR_CMD_SERR_BIT 8
`define ABR_CMD_SEC_SERR_BIT 0
`define ABR_CMD_WMASK 32'h0000_0101
`define ABR_RESET_BYTE 8'h00
`define ABR_IRQ_PARITY_BIT 0
`define ABR_IRQ_TA_BIT 1
`define ABR_IRQ_MA_BIT 2
`define ABR_IRQ_SERR_BIT 3
// ---------------------------------------------------------------
// Legacy video ranges
// ---------------------------------------------------------------
`define ABR_VMEM_LO 32'h000a_0000
`define ABR_VMEM_HI 32'h000b_ffff
`define ABR_VIO1_LO 10'h3b0
`define ABR_VIO1_HI 10'h3bb
`define ABR_VIO2_LO 10'h3c0
`define ABR_VIO2_HI 10'h3df
`define ABR_ISA_ALIAS_LO 10'h100
`define ABR_ALL_ONES 32'hffff_ffff
`endif

/* File: design/abr_pkg.sv */
package abr_pkg;
   typedef enum logic [1:0] {ABR_RESP_OKAY = 2'b00, ABR_RESP_SLVERR = 2'b10} abr_resp_t;
   typedef enum logic {ABR_ROUTE_HUB = 1'b0, ABR_ROUTE_AGP = 1'b1} abr_route_t;
endpackage

/* File: design/abr_route.sv */
`timescale 1ns/1ps
`include "abr_defs.svh"
// Combinational routing decision for one host access
module abr_route
   import abr_pkg::*;
(
   input wire logic is_io,
   input wire logic [31:0] addr,
   input wire logic video_en,
   input wire logic isa_en,
   input wire logic [31:0] io_win,
   input wire logic [31:0] mem_win,
   input wire logic [31:0] pref_win,
   output abr_route_t route
);
   logic in_io;
   logic in_mem;
   logic in_pref;
   logic video_hit;
   logic isa_alias;
   // ---------------------------------------------------------------
   // Window decode
   // ---------------------------------------------------------------
   // I/O window: base/limit in 4 KB units, limit low bits all ones
   assign in_io = is_io && (addr[15:12] >= io_win[7:4]) && (addr[15:12] <= io_win[15:12]);
   // Memory windows: 1 MB granularity, A[19:0] treated as FFFFFh at the limit
   assign in_mem = !is_io && (addr[31:20] >= mem_win[15:4]) && (addr[31:20] <= mem_win[31:20]);
   assign in_pref = !is_io && (addr[31:20] >= pref_win[15:4])
      && (addr[31:20] <= pref_win[31:20]);
   // Video ranges, A[15:10] ignored for I/O
   assign video_hit = is_io ?
      (((addr[9:0] >= `ABR_VIO1_LO) && (addr[9:0] <= `ABR_VIO1_HI))
      || ((addr[9:0] >= `ABR_VIO2_LO) && (addr[9:0] <= `ABR_VIO2_HI))) :
      ((addr >= `ABR_VMEM_LO) && (addr <= `ABR_VMEM_HI));
   // Upper 768 bytes of each 1 KB block
   assign isa_alias = (addr[9:0] >= `ABR_ISA_ALIAS_LO);
   // ---------------------------------------------------------------
   // Decision
   // ---------------------------------------------------------------
   always_comb begin
      route = ABR_ROUTE_HUB;
      if (video_en && video_hit) begin
         route = ABR_ROUTE_AGP;
      end else if (in_io) begin
         // Alias only trims accesses already inside the I/O window
         route = (isa_en && isa_alias) ? ABR_ROUTE_HUB : ABR_ROUTE_AGP;
      end else if (in_mem || in_pref) begin
         route = ABR_ROUTE_AGP;
      end
   end
endmodule // abr_route

/* File: design/abr_serr.sv */
`timescale 1ns/1ps
`include "abr_defs.svh"
// Decides whether a pulse of each error class becomes an SERR message
module abr_serr
   import abr_pkg::*;
(
   input wire logic parity_err,
   input wire logic target_abort,
   input wire logic other_err,
   input wire logic parity_en,
   input wire logic ta_en,
   input wire logic sec_serr_en,
   input wire logic serr_en,
   output logic send
);
   logic par_req;
   logic ta_req;
   // Parity needs both its own enable and the secondary enable
   assign par_req = parity_err && parity_en && sec_serr_en;
   assign ta_req = target_abort && ta_en;
   // Global enable gates every class; other errors ignore parity_en
   assign send = serr_en && (par_req || ta_req || other_err);
endmodule // abr_serr

/* File: design/abr_bridge.sv */
`timescale 1ns/1ps
`include "abr_defs.svh"
// What this block does
// - Video enable sends legacy-video memory and I/O to AGP, ignoring windows.
// - Video enable forwards legacy-video ranges regardless of ISA alias enable.
// - Video enable clear: legacy ranges go to hub unless inside an AGP window.
// - ISA alias applies only to I/O accesses inside the AGP I/O window.
// - ISA alias set: upper 768 bytes of each 1 KB go to hub.
// - ISA alias clear: every I/O in the I/O window goes to AGP.
// - Parity enable and secondary SERR enable report AGP parity errors as SERR.
// - Parity enable clear blocks parity SERR only; other errors still report.
// - No parity error pin; parity errors reported by messaging and in irq_status bit 0.
// - Target-abort enable set: each received target abort sends SERR.
// - Target-abort enable clear: target aborts send no SERR.
// - Every SERR needs the global SERR enable of the command register.
// - Error command register at 40h, resets 00h, only bit 0 writable.
// - Video ranges are A0000h-BFFFFh and I/O 3B0-3BB, 3C0-3DF, A[15:10] ignored.
// - Master abort drops write data and returns all ones on reads.
module abr_bridge
   import abr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Host access to route
   input wire logic host_valid,
   input wire logic host_is_io,
   input wire logic [31:0] host_addr,
   output logic route_valid,
   output logic route_agp,
   // AGP master completion
   input wire logic agp_done,
   input wire logic agp_master_abort,
   input wire logic agp_is_read,
   input wire logic [31:0] agp_rdata,
   output logic cpl_valid,
   output logic [31:0] cpl_rdata,
   output logic cpl_wr_commit,
   // Error events, one-cycle pulses
   input wire logic agp_parity_err,
   input wire logic agp_target_abort,
   input wire logic other_err,
   output logic hub_serr_msg,
   output logic irq
);
   logic [7:0] bridge_control;
   logic [7:0] error_command;
   logic [31:0] bridge_command_reg;
   logic [31:0] agp_io_window;
   logic [31:0] agp_mem_window;
   logic [31:0] agp_pref_window;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic do_read;
   logic wr_mapped;
   logic [31:0] rd_val;
   logic rd_mapped;
   logic [31:0] wmask;
   abr_route_t route_now;
   logic serr_now;
   logic [3:0] events;
   logic [3:0] clr_bits;
   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   // Address and data captured independently, in either order
   assign do_write = aw_held && w_held && !s_bvalid;
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_awvalid && s_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_wvalid && s_wready) begin
         w_held <= 1'b1;
         w_data <= s_wdata;
         w_strb <= s_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end
   // Ready only while the holding slot is empty
   always_ff @(posedge clk) begin
      if (rst) begin
         s_awready <= 1'b0;
         s_wready <= 1'b0;
      end else begin
         s_awready <= !aw_held && !(s_awvalid && s_awready);
         s_wready <= !w_held && !(s_wvalid && s_wready);
      end
   end
   always_comb begin
      unique case (aw_addr)
         `ABR_OFF_BRIDGE_CONTROL, `ABR_OFF_ERROR_COMMAND, `ABR_OFF_COMMAND,
         `ABR_OFF_IO_WINDOW, `ABR_OFF_MEM_WINDOW, `ABR_OFF_PREF_WINDOW,
         `ABR_OFF_IRQ_STATUS, `ABR_OFF_IRQ_MASK: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_bvalid <= 1'b0;
         s_bresp <= ABR_RESP_OKAY;
      end else if (do_write) begin
         s_bvalid <= 1'b1;
         s_bresp <= wr_mapped ? ABR_RESP_OKAY : ABR_RESP_SLVERR;
      end else if (s_bready) begin
         s_bvalid <= 1'b0;
      end
   end
   // Byte-lane mask of the pending write
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{w_strb[i]}};
      end
   end
   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   // Only writable bits take data; reserved bits stay zero
   always_ff @(posedge clk) begin
      if (rst) begin
         bridge_control <= `ABR_RESET_BYTE;
         error_command <= `ABR_RESET_BYTE;
         bridge_command_reg <= 32'h0000_0000;
      end else if (do_write && w_strb[0] && aw_addr == `ABR_OFF_BRIDGE_CONTROL) begin
         bridge_control <= w_data[7:0] & `ABR_BC_WMASK;
      end else if (do_write && w_strb[0] && aw_addr == `ABR_OFF_ERROR_COMMAND) begin
         error_command <= w_data[7:0] & `ABR_EC_WMASK;
      end else if (do_write && aw_addr == `ABR_OFF_COMMAND) begin
         bridge_command_reg <= (bridge_command_reg & ~wmask)
            | (w_data & wmask & `ABR_CMD_WMASK);
      end
   end
   // Window registers: memory base in low half, limit in high half; I/O base in byte 0, limit in byte 1
   always_ff @(posedge clk) begin
      if (rst) begin
         agp_io_window <= 32'h0000_0000;
         agp_mem_window <= 32'h0000_0000;
         agp_pref_window <= 32'h0000_0000;
      end else if (do_write && aw_addr == `ABR_OFF_IO_WINDOW) begin
         agp_io_window <= (agp_io_window & ~wmask) | (w_data & wmask & 32'h0000_f0f0);
      end else if (do_write && aw_addr == `ABR_OFF_MEM_WINDOW) begin
         agp_mem_window <= (agp_mem_window & ~wmask) | (w_data & wmask & 32'hfff0_fff0);
      end else if (do_write && aw_addr == `ABR_OFF_PREF_WINDOW) begin
         agp_pref_window <= (agp_pref_window & ~wmask) | (w_data & wmask & 32'hfff0_fff0);
      end
   end
   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   assign do_read = s_arvalid && s_arready;
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_mapped = 1'b1;
      unique case (s_araddr)
         `ABR_OFF_BRIDGE_CONTROL: rd_val = {24'h000000, bridge_control};
         `ABR_OFF_ERROR_COMMAND: rd_val = {24'h000000, error_command};
         `ABR_OFF_COMMAND: rd_val = bridge_command_reg;
         `ABR_OFF_IO_WINDOW: rd_val = agp_io_window;
         `ABR_OFF_MEM_WINDOW: rd_val = agp_mem_window;
         `ABR_OFF_PREF_WINDOW: rd_val = agp_pref_window;
         `ABR_OFF_IRQ_STATUS: rd_val = {28'h0000000, irq_status};
         `ABR_OFF_IRQ_MASK: rd_val = {28'h0000000, irq_mask};
         default: rd_mapped = 1'b0;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= ABR_RESP_OKAY;
      end else if (do_read) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b1;
         s_rdata <= rd_val;
         s_rresp <= rd_mapped ? ABR_RESP_OKAY : ABR_RESP_SLVERR;
      end else if (s_rvalid) begin
         s_arready <= 1'b0;
         if (s_rready) begin
            s_rvalid <= 1'b0;
         end
      end else begin
         s_arready <= 1'b1;
      end
   end
   // ---------------------------------------------------------------
   // Host routing
   // ---------------------------------------------------------------
   abr_route u_route (
      .is_io(host_is_io),
      .addr(host_addr),
      .video_en(bridge_control[`ABR_BC_VIDEO_BIT]),
      .isa_en(bridge_control[`ABR_BC_ISA_BIT]),
      .io_win(agp_io_window),
      .mem_win(agp_mem_window),
      .pref_win(agp_pref_window),
      .route(route_now)
   );
   // Registered so the output comes straight from a flop
   always_ff @(posedge clk) begin
      if (rst) begin
         route_valid <= 1'b0;
         route_agp <= 1'b0;
      end else begin
         route_valid <= host_valid;
         route_agp <= host_valid && (route_now == ABR_ROUTE_AGP);
      end
   end
   // ---------------------------------------------------------------
   // AGP master completion
   // ---------------------------------------------------------------
   // Master abort: reads see all ones, writes are never committed
   always_ff @(posedge clk) begin
      if (rst) begin
         cpl_valid <= 1'b0;
         cpl_rdata <= 32'h0000_0000;
         cpl_wr_commit <= 1'b0;
      end else begin
         cpl_valid <= agp_done;
         cpl_rdata <= (agp_done && agp_is_read) ?
            (agp_master_abort ? `ABR_ALL_ONES : agp_rdata) : 32'h0000_0000;
         cpl_wr_commit <= agp_done && !agp_is_read && !agp_master_abort;
      end
   end
   // ---------------------------------------------------------------
   // SERR messaging and interrupts
   // ---------------------------------------------------------------
   // No parity pin exists; parity leaves as a hub message and sets irq_status bit 0
   abr_serr u_serr (
      .parity_err(agp_parity_err),
      .target_abort(agp_target_abort),
      .other_err(other_err),
      .parity_en(bridge_control[`ABR_BC_PARITY_BIT]),
      .ta_en(error_command[`ABR_EC_TA_BIT]),
      .sec_serr_en(bridge_command_reg[`ABR_CMD_SEC_SERR_BIT]),
      .serr_en(bridge_command_reg[`ABR_CMD_SERR_BIT]),
      .send(serr_now)
   );
   always_ff @(posedge clk) begin
      if (rst) begin
         hub_serr_msg <= 1'b0;
      end else begin
         hub_serr_msg <= serr_now;
      end
   end
   assign events = {serr_now, agp_done && agp_master_abort, agp_target_abort, agp_parity_err};
   assign clr_bits = (do_write && w_strb[0] && aw_addr == `ABR_OFF_IRQ_STATUS) ?
      w_data[3:0] : 4'h0;
   // Set wins over a simultaneous write-one clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= 4'h0;
         irq_mask <= 4'h0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~clr_bits) | events;
         if (do_write && w_strb[0] && aw_addr == `ABR_OFF_IRQ_MASK) begin
            irq_mask <= w_data[3:0];
         end
         irq <= |(((irq_status & ~clr_bits) | events) & irq_mask);
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_video_io;
      host_valid && host_is_io && bridge_control[`ABR_BC_VIDEO_BIT]
         && host_addr[9:0] >= 10'h3c0 && host_addr[9:0] <= 10'h3df;
   endsequence
   property p_video_fwd;
      @(posedge clk) disable iff (rst) s_video_io |=> route_agp;
   endproperty
   a_video_fwd: assert property (p_video_fwd) else $error("video io not to agp");
   property p_video_isa;
      @(posedge clk) disable iff (rst)
         s_video_io ##0 bridge_control[`ABR_BC_ISA_BIT] |=> route_agp;
   endproperty
   a_video_isa: assert property (p_video_isa) else $error("isa overrode video");
   property p_video_off;
      @(posedge clk) disable iff (rst)
         host_valid && !host_is_io && !bridge_control[`ABR_BC_VIDEO_BIT]
         && host_addr[31:16] == 16'h000a && agp_mem_window[15:4] > agp_mem_window[31:20]
         && agp_pref_window[15:4] > agp_pref_window[31:20] |=> !route_agp;
   endproperty
   a_video_off: assert property (p_video_off) else $error("video mem to agp when off");
   property p_isa_alias;
      @(posedge clk) disable iff (rst)
         host_valid && host_is_io && bridge_control[`ABR_BC_ISA_BIT]
         && !bridge_control[`ABR_BC_VIDEO_BIT] && host_addr[9:8] != 2'b00 |=> !route_agp;
   endproperty
   a_isa_alias: assert property (p_isa_alias) else $error("isa alias went to agp");
   property p_parity_block;
      @(posedge clk) disable iff (rst)
         agp_parity_err && !bridge_control[`ABR_BC_PARITY_BIT] && !agp_target_abort
         && !other_err |=> !hub_serr_msg;
   endproperty
   a_parity_block: assert property (p_parity_block) else $error("parity serr when off");
   property p_ta_serr;
      @(posedge clk) disable iff (rst)
         agp_target_abort && error_command[0] && bridge_command_reg[8] |=> hub_serr_msg;
   endproperty
   a_ta_serr: assert property (p_ta_serr) else $error("target abort lost");
   property p_global_serr;
      @(posedge clk) disable iff (rst) !$past(bridge_command_reg[8]) |-> !hub_serr_msg;
   endproperty
   a_global_serr: assert property (p_global_serr) else $error("serr without enable");
   property p_errcmd_resv;
      @(posedge clk) disable iff (rst) error_command[7:1] == 7'h00;
   endproperty
   a_errcmd_resv: assert property (p_errcmd_resv) else $error("reserved bits set");
   property p_mabort;
      @(posedge clk) disable iff (rst)
         agp_done && agp_master_abort |=> !cpl_wr_commit && (!$past(agp_is_read)
         || cpl_rdata == 32'hffff_ffff);
   endproperty
   a_mabort: assert property (p_mabort) else $error("master abort data wrong");
endmodule // abr_bridge

/* File: testbench/abr_agp_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Graphics device answering AGP master cycles
// ---------------------------------------------
module abr_agp_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic abort,
   input wire logic rd,
   input wire logic [31:0] data,
   input wire logic [3:0] lat,
   output logic agp_done,
   output logic agp_master_abort,
   output logic agp_is_read,
   output logic [31:0] agp_rdata
);
   logic busy;
   logic [3:0] cnt;

   // Ends a cycle lat+1 clocks after go is sampled; idle qualifiers toggle so stale values never pass
   always_ff @(posedge clk) begin
      agp_done <= 1'b0;
      if (rst) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         agp_master_abort <= 1'b0;
         agp_is_read <= 1'b0;
         agp_rdata <= 32'h0;
      end else if (go) begin
         busy <= 1'b1;
         cnt <= lat;
      end else if (busy && cnt == 4'h0) begin
         busy <= 1'b0;
         agp_done <= 1'b1;
         agp_master_abort <= abort;
         agp_is_read <= rd;
         agp_rdata <= abort ? ~data : data; // Nobody drives data on an abort
      end else begin
         cnt <= cnt - 4'h1;
         agp_master_abort <= ~agp_master_abort;
         agp_is_read <= ~agp_is_read;
         agp_rdata <= ~agp_rdata;
      end
   end
endmodule // abr_agp_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
// ---------------------------------------------
// Bench top
// ---------------------------------------------
module tb_top;
   typedef struct {logic [7:0] bc; logic [31:0] iow, mw; logic io; logic [31:0] a;
      logic e;} abr_row_t;
   localparam logic [31:0] IOE = 32'hf0, IO1 = 32'h1010, MEME = 32'hfff0;
   // Window set-up, access, expected AGP route
   abr_row_t rows [22] = '{
      '{8'h08, IOE, MEME, 0, 32'ha0000, 1}, '{8'h08, IOE, MEME, 0, 32'hbffff, 1},
      '{8'h08, IOE, MEME, 0, 32'hc0000, 0}, '{8'h08, IOE, MEME, 0, 32'h9ffff, 0},
      '{8'h08, IOE, MEME, 1, 32'h3b0, 1}, '{8'h08, IOE, MEME, 1, 32'h3bc, 0},
      '{8'h08, IOE, MEME, 1, 32'h3df, 1}, '{8'h08, IOE, MEME, 1, 32'h3e0, 0},
      '{8'h08, IOE, MEME, 1, 32'h7fc5, 1}, '{8'h0c, IO1, MEME, 1, 32'h13b0, 1},
      '{8'h00, IOE, MEME, 0, 32'ha0000, 0}, '{8'h00, IOE, 32'h0, 0, 32'ha0000, 1},
      '{8'h00, IOE, MEME, 1, 32'h3c0, 0}, '{8'h00, 32'h0, MEME, 1, 32'h3c0, 1},
      '{8'h04, IO1, MEME, 1, 32'h1000, 1}, '{8'h04, IO1, MEME, 1, 32'h10ff, 1},
      '{8'h04, IO1, MEME, 1, 32'h1100, 0}, '{8'h04, IO1, MEME, 1, 32'h1fff, 0},
      '{8'h04, IOE, 32'h0, 0, 32'h100, 1}, '{8'h04, IO1, MEME, 1, 32'h2000, 0},
      '{8'h00, IO1, MEME, 1, 32'h1100, 1}, '{8'h00, IO1, MEME, 1, 32'h1fff, 1}};
   logic [7:0] regs [5] = '{8'h3c, 8'h40, 8'h44, 8'h54, 8'h58};
   logic clk = 0, rst = 1;
   logic [7:0] s_awaddr = 0, s_araddr = 0;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
   logic [31:0] s_wdata = 0, host_addr = 0, gd = 0, rv, s_rdata, agp_rdata, cpl_rdata;
   logic [3:0] s_wstrb = 0, lat = 0;
   logic [1:0] s_bresp, s_rresp, rsp;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, route_valid, route_agp;
   logic host_valid = 0, host_is_io = 0, go = 0, ab = 0, rd = 0;
   logic agp_done, agp_master_abort, agp_is_read, cpl_valid, cpl_wr_commit, hub_serr_msg, irq;
   logic agp_parity_err = 0, agp_target_abort = 0, other_err = 0;
   int bad_count = 0, checks = 0, cyc = 0;

   abr_bridge uut (.clk, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .host_valid, .host_is_io,
      .host_addr, .route_valid, .route_agp, .agp_done, .agp_master_abort, .agp_is_read,
      .agp_rdata, .cpl_valid, .cpl_rdata, .cpl_wr_commit, .agp_parity_err,
      .agp_target_abort, .other_err, .hub_serr_msg, .irq);
   abr_agp_model agp (.clk, .rst, .go, .abort(ab), .rd, .data(gd), .lat, .agp_done,
      .agp_master_abort, .agp_is_read, .agp_rdata);

   // 40 MHz clock and a cycle ceiling that cuts a hang short
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task complete_run;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Address and data offered together, each dropped once taken
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
         output logic [1:0] r);
      logic aw, w;
      @(posedge clk);
      s_awaddr <= a;
      s_awvalid <= 1;
      s_wdata <= d;
      s_wstrb <= st;
      s_wvalid <= 1;
      s_bready <= 1;
      aw = 0;
      w = 0;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && s_awready) begin
            aw = 1;
            s_awvalid <= 0;
         end
         if (!w && s_wready) begin
            w = 1;
            s_wvalid <= 0;
         end
      end
      do @(posedge clk); while (!s_bvalid);
      r = s_bresp;
      s_bready <= 0;
   endtask

   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1;
      s_rready <= 1;
      do @(posedge clk); while (!s_arready);
      s_arvalid <= 0;
      do @(posedge clk); while (!s_rvalid);
      d = s_rdata;
      r = s_rresp;
      s_rready <= 0;
   endtask

   task route_chk(input logic io, input logic [31:0] a, input logic e);
      @(posedge clk);
      host_valid <= 1;
      host_is_io <= io;
      host_addr <= a;
      @(posedge clk);
      host_valid <= 0;
      #1;
      chk("route_valid", 1, route_valid);
      chk("route_agp", e, route_agp);
   endtask

   // Error event of class k held n cycles; message checked against e each of them, then quiet
   task ev(input int k, input logic e, input int n);
      @(posedge clk);
      agp_parity_err <= (k == 0);
      agp_target_abort <= (k == 1);
      other_err <= (k == 2);
      for (int j = 0; j < n; j++) begin
         @(posedge clk);
         if (j == n - 1) begin
            agp_parity_err <= 0;
            agp_target_abort <= 0;
            other_err <= 0;
         end
         #1;
         chk("hub_serr_msg", e, hub_serr_msg);
      end
      @(posedge clk);
      #1;
      chk("hub_serr_msg", 0, hub_serr_msg);
   endtask

   task cpl(input logic a, input logic r, input logic [31:0] d, input logic [3:0] l,
         input logic [31:0] er, input logic ec);
      @(posedge clk);
      go <= 1;
      ab <= a;
      rd <= r;
      gd <= d;
      lat <= l;
      @(posedge clk);
      go <= 0;
      do @(posedge clk); while (!cpl_valid);
      chk("cpl_rdata", er, cpl_rdata);
      chk("cpl_wr_commit", ec, cpl_wr_commit);
   endtask

   // Main sequence: registers, route table, error gating, completions, interrupt
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      foreach (regs[i]) begin
         axi_rd(regs[i], rv, rsp);
         chk("reset_value", 0, rv);
      end
      axi_wr(8'h40, 32'hff, 4'hf, rsp);
      axi_rd(8'h40, rv, rsp);
      chk("error_command", 32'h1, rv);
      axi_wr(8'h3c, 32'hff, 4'hf, rsp);
      axi_wr(8'h3c, 32'h0, 4'he, rsp);
      axi_rd(8'h3c, rv, rsp);
      chk("bridge_control", 32'hd, rv);
      axi_wr(8'h44, 32'hffffffff, 4'hf, rsp);
      axi_rd(8'h44, rv, rsp);
      chk("command", 32'h101, rv);
      axi_rd(8'h80, rv, rsp);
      chk("rresp_unmapped", 32'h2, {30'h0, rsp});
      axi_wr(8'h84, 32'h1, 4'hf, rsp);
      chk("bresp_unmapped", 32'h2, {30'h0, rsp});
      axi_wr(8'h50, MEME, 4'hf, rsp);
      foreach (rows[i]) begin
         axi_wr(8'h3c, {24'h0, rows[i].bc}, 4'hf, rsp);
         axi_wr(8'h48, rows[i].iow, 4'hf, rsp);
         axi_wr(8'h4c, rows[i].mw, 4'hf, rsp);
         route_chk(rows[i].io, rows[i].a, rows[i].e);
      end
      for (int i = 0; i < 16; i++) begin
         axi_wr(8'h44, {23'h0, i[3], 7'h0, i[2]}, 4'hf, rsp);
         axi_wr(8'h3c, {31'h0, i[1]}, 4'hf, rsp);
         axi_wr(8'h40, {31'h0, i[0]}, 4'hf, rsp);
         ev(0, i[3] & i[2] & i[1], 1);
         ev(1, i[3] & i[0], 1);
         ev(2, i[3], 1);
      end
      ev(1, 1, 2);
      axi_wr(8'h54, 32'hf, 4'hf, rsp);
      axi_wr(8'h58, 32'h4, 4'hf, rsp);
      cpl(1, 1, 32'h12345678, 4'h5, 32'hffffffff, 0);
      cpl(0, 1, 32'h12345678, 4'h0, 32'h12345678, 0);
      cpl(0, 0, 32'h5a5a0f0f, 4'h2, 32'h0, 1);
      cpl(1, 0, 32'h5a5a0f0f, 4'h0, 32'h0, 0);
      axi_rd(8'h54, rv, rsp);
      chk("irq_status", 32'h4, rv);
      chk("irq", 1, irq);
      axi_wr(8'h54, 32'h4, 4'hf, rsp);
      ev(0, 1, 1);
      axi_rd(8'h54, rv, rsp);
      chk("irq_status", 32'h9, rv);
      chk("irq_masked", 0, irq);
      axi_wr(8'h58, 32'h1, 4'hf, rsp);
      axi_rd(8'h54, rv, rsp);
      chk("irq", 1, irq);
      axi_wr(8'h54, 32'hf, 4'hf, rsp);
      axi_rd(8'h54, rv, rsp);
      chk("irq_status", 32'h0, rv);
      chk("irq_cleared", 0, irq);
      // Mid-run reset must drop the error command and bridge control enables set above back to zero
      @(posedge clk);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      repeat (2) @(posedge clk);
      axi_rd(8'h40, rv, rsp);
      chk("error_command_rst", 32'h0, rv);
      axi_rd(8'h3c, rv, rsp);
      chk("bridge_control_rst", 32'h0, rv);
      chk("irq_rst", 0, irq);
      complete_run();
   end
endmodule // tb_top
